// file: rtl/dcst_pkg.sv
// package of register map, field layout and spacing constants for the command spacing timer
package dcst_pkg;
  localparam logic [7:0] ADDR_READ_TURNAROUND   = 8'h58;
  localparam logic [7:0] ADDR_ACT_CLK_BURST     = 8'h5c;
  localparam logic [7:0] ADDR_CMD_TIMING        = 8'h70;
  localparam logic [7:0] ADDR_STATUS            = 8'h74;
  localparam int         FLD_W                  = 3;
  localparam int         POS_RD_WR_SAME         = 24;
  localparam int         POS_RD_WR_DIFF         = 16;
  localparam int         POS_RD_RD_SAME         = 8;
  localparam int         POS_RD_RD_DIFF         = 0;
  localparam int         POS_ACT_ACT            = 24;
  localparam int         POS_CLK_DISABLE        = 16;
  localparam int         POS_MIN_CKE            = 8;
  localparam int         POS_BURST_INT          = 0;
  localparam int         POS_TCCD               = 0;
  localparam int         POS_BURST_LEN          = 8;
  localparam logic [31:0] RESET_READ_TURNAROUND = 32'h0000_0000;
  localparam logic [31:0] RESET_ACT_CLK_BURST   = 32'h0000_0000;
  localparam logic [31:0] RESET_CMD_TIMING      = 32'h0000_0402;
  localparam logic [31:0] MASK_TURNAROUND       = 32'h0707_0707;
  localparam logic [31:0] MASK_CMD_TIMING       = 32'h0000_0707;
  localparam logic [2:0] CMD_NONE  = 3'h0;
  localparam logic [2:0] CMD_READ  = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_ACT   = 3'h3;
  localparam logic [2:0] CMD_OTHER = 3'h4;
endpackage

// file: rtl/dcst_cfg_if.sv
// interface carrying programmed timing fields from the register file to the spacing logic
`timescale 1ns/1ns
interface dcst_cfg_if;
  logic [2:0] rd_wr_same;
  logic [2:0] rd_wr_diff;
  logic [2:0] rd_rd_same;
  logic [2:0] rd_rd_diff;
  logic [2:0] act_act;
  logic [2:0] clk_disable;
  logic [2:0] burst_int;
  logic [2:0] tccd;
  logic [2:0] burst_len;
  modport regs (output rd_wr_same, rd_wr_diff, rd_rd_same, rd_rd_diff, act_act, clk_disable, burst_int, tccd,
                burst_len);
  modport core (input rd_wr_same, rd_wr_diff, rd_rd_same, rd_rd_diff, act_act, clk_disable, burst_int, tccd,
                burst_len);
endinterface

// file: rtl/dcst_regs.sv
// apb register file holding the spacing fields
`timescale 1ns/1ns
module dcst_regs
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] status,
  output logic      [31:0] prdata,
  output logic             pslverr,
  dcst_cfg_if.regs         cfg
);
  logic [31:0] turn;
  logic [31:0] act;
  logic [31:0] cmdt;
  logic [31:0] next_turn;
  logic [31:0] next_act;
  logic [31:0] next_cmdt;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        hit;

  always_comb
  begin
    next_turn    = turn;
    next_act     = act;
    next_cmdt    = cmdt;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    hit          = 1'b1;
    // zero-wait-state slave: act during setup, answer appears on the access cycle
    if (psel && !penable)
    begin
      if (paddr == dcst_pkg::ADDR_READ_TURNAROUND)
      begin
        if (pwrite) next_turn = pwdata & dcst_pkg::MASK_TURNAROUND;
        next_prdata = turn;
      end
      else if (paddr == dcst_pkg::ADDR_ACT_CLK_BURST)
      begin
        if (pwrite) next_act = pwdata & dcst_pkg::MASK_TURNAROUND;
        next_prdata = act;
      end
      else if (paddr == dcst_pkg::ADDR_CMD_TIMING)
      begin
        if (pwrite) next_cmdt = pwdata & dcst_pkg::MASK_CMD_TIMING;
        next_prdata = cmdt;
      end
      else if (paddr == dcst_pkg::ADDR_STATUS)
      begin
        next_prdata = status;
        next_pslverr = pwrite;
      end
      else
      begin
        hit = 1'b0;
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b1;
      end
      if (!hit) next_prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      turn    <= dcst_pkg::RESET_READ_TURNAROUND;
      act     <= dcst_pkg::RESET_ACT_CLK_BURST;
      cmdt    <= dcst_pkg::RESET_CMD_TIMING;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      turn    <= next_turn;
      act     <= next_act;
      cmdt    <= next_cmdt;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign cfg.rd_wr_same  = turn[dcst_pkg::POS_RD_WR_SAME +: dcst_pkg::FLD_W];
  assign cfg.rd_wr_diff  = turn[dcst_pkg::POS_RD_WR_DIFF +: dcst_pkg::FLD_W];
  assign cfg.rd_rd_same  = turn[dcst_pkg::POS_RD_RD_SAME +: dcst_pkg::FLD_W];
  assign cfg.rd_rd_diff  = turn[dcst_pkg::POS_RD_RD_DIFF +: dcst_pkg::FLD_W];
  assign cfg.act_act     = act[dcst_pkg::POS_ACT_ACT +: dcst_pkg::FLD_W];
  assign cfg.clk_disable = act[dcst_pkg::POS_CLK_DISABLE +: dcst_pkg::FLD_W];
  assign cfg.burst_int   = act[dcst_pkg::POS_BURST_INT +: dcst_pkg::FLD_W];
  assign cfg.tccd        = cmdt[dcst_pkg::POS_TCCD +: dcst_pkg::FLD_W];
  assign cfg.burst_len   = cmdt[dcst_pkg::POS_BURST_LEN +: dcst_pkg::FLD_W];
endmodule

// file: rtl/dcst_burst.sv
// burst-interrupt down-counter and column-to-column gap tracker
`timescale 1ns/1ns
module dcst_burst
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  col_issue,
  dcst_cfg_if.core   cfg,
  output logic       burst_busy,
  output logic       intr_ok
);
  logic [2:0] bi_cnt;
  logic [2:0] beat_cnt;
  logic [2:0] ccd_cnt;
  logic [2:0] next_bi_cnt;
  logic [2:0] next_beat_cnt;
  logic [2:0] next_ccd_cnt;

  always_comb
  begin
    next_bi_cnt   = bi_cnt;
    next_beat_cnt = beat_cnt;
    next_ccd_cnt  = (ccd_cnt != 3'h0) ? ccd_cnt - 3'h1 : 3'h0;
    if (col_issue)
    begin
      next_bi_cnt   = cfg.burst_int;  // [RULE8]
      next_beat_cnt = cfg.burst_len;
      next_ccd_cnt  = cfg.tccd;
    end
    else if (beat_cnt != 3'h0)
    begin
      next_beat_cnt = beat_cnt - 3'h1;
      if (bi_cnt == 3'h0)
        next_bi_cnt = cfg.burst_int;  // [RULE10]
      else
        next_bi_cnt = bi_cnt - 3'h1;
    end
    else
      next_bi_cnt = 3'h0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bi_cnt   <= 3'h0;  // [RULE12]
      beat_cnt <= 3'h0;
      ccd_cnt  <= 3'h0;
    end
    else
    begin
      bi_cnt   <= next_bi_cnt;
      beat_cnt <= next_beat_cnt;
      ccd_cnt  <= next_ccd_cnt;
    end
  end

  assign burst_busy = (beat_cnt != 3'h0);
  // an unfinished burst may be cut only once both the counter and tccd have run out
  assign intr_ok = !burst_busy || ((bi_cnt == 3'h0) && (ccd_cnt == 3'h0));  // [RULE9] [RULE11]

  a_burst_load: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE8]
    col_issue |=> bi_cnt == $past(cfg.burst_int)) else $error("burst counter not loaded");
  a_burst_reload: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE10]
    (!col_issue && burst_busy && bi_cnt == 3'h0) |=> bi_cnt == $past(cfg.burst_int))
    else $error("burst counter not reloaded");
  a_ccd_gap: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE11]
    (col_issue && cfg.tccd != 3'h0 && cfg.burst_len != 3'h0) |=> !intr_ok)
    else $error("interrupt allowed before tccd");
endmodule

// file: rtl/dcst_top.sv
// command spacing timer: turnaround, activate spacing and burst-interrupt gating
// What this block does
// RULE1: a write after a read to the same chip select waits the programmed extra cycles, at least one.
// RULE2: a write after a read to another chip select waits the programmed extra cycles, at least one.
// RULE3: a read after a read to the same chip select waits the programmed additional delay.
// RULE4: a read after a read to another chip select waits the programmed extra cycles, at least one.
// RULE5: activates to different banks stay at least the programmed activate spacing apart.
// RULE6: the clock-disable field holds the cycles the phy needs to stop the memory clock.
// RULE7: software sets that field to the pad re-enable time when the disable also gates the pads.
// RULE8: issuing a burst loads the burst-interrupt down-counter with the programmed interval.
// RULE9: no command may cut into an unfinished burst before that counter reaches zero.
// RULE10: when the counter hits zero with the burst unfinished it reloads the interval.
// RULE11: a cutting command also waits tccd cycles after the last column command.
// RULE12: all delays are counted in controller clocks by counters cleared at reset; elapsed and act_since reset to 7 instead.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module dcst_top
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CMD_VALID,
  input  wire logic [2:0]  CMD_TYPE,
  input  wire logic        CMD_CS,
  input  wire logic [2:0]  CMD_BANK,
  output logic             CMD_ACCEPT,
  output logic             CMD_READY,
  input  wire logic        CLK_DISABLE_REQ,
  output logic             DFI_DRAM_CLK_DISABLE,
  output logic             DRAM_CLK_STOPPED
);
  typedef enum logic [1:0]
  {
    DCST_CK_RUN  = 2'b00,
    DCST_CK_WAIT = 2'b01,
    DCST_CK_OFF  = 2'b10
  } dcst_ck_t;

  dcst_cfg_if cfg ();

  logic [31:0] status;
  logic        burst_busy;
  logic        intr_ok;
  logic        take;
  logic        is_rd;
  logic        is_wr;
  logic        is_act;
  logic        is_col;
  logic        space_ok;
  logic [2:0]  rd_gap;
  logic        last_cs;
  logic        last_bank_valid;
  logic [2:0]  last_bank;
  logic [3:0]  next_rd_gap;
  logic        next_last_cs;
  logic [2:0]  act_gap;
  logic [2:0]  next_act_gap;
  logic        next_last_bank_valid;
  logic [2:0]  next_last_bank;
  logic        need_gap;
  logic [2:0]  need_val;
  dcst_ck_t    ck_state;
  dcst_ck_t    next_ck_state;
  logic [2:0]  ck_cnt;
  logic [2:0]  next_ck_cnt;
  logic        next_cmd_ready;
  logic        next_pready;
  logic [2:0]  elapsed;
  logic [2:0]  next_elapsed;
  logic [2:0]  act_since;
  logic [2:0]  next_act_since;

  dcst_regs u_regs
  (
    .clk     (CLK),
    .rst_n   (RSTN),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .status  (status),
    .prdata  (PRDATA),
    .pslverr (PSLVERR),
    .cfg     (cfg.regs)
  );

  dcst_burst u_burst
  (
    .clk        (CLK),
    .rst_n      (RSTN),
    .col_issue  (take && is_col),
    .cfg        (cfg.core),
    .burst_busy (burst_busy),
    .intr_ok    (intr_ok)
  );

  assign is_rd  = (CMD_TYPE == dcst_pkg::CMD_READ);
  assign is_wr  = (CMD_TYPE == dcst_pkg::CMD_WRITE);
  assign is_act = (CMD_TYPE == dcst_pkg::CMD_ACT);
  assign is_col = is_rd || is_wr;

  // each follower type waits its own field, counted in idle cycles since the last read
  always_comb
  begin
    need_gap = 1'b0;
    need_val = 3'h0;
    if (is_wr && CMD_CS == last_cs)
      need_val = cfg.rd_wr_same;  // [RULE1]
    else if (is_wr)
      need_val = cfg.rd_wr_diff;  // [RULE2]
    else if (is_rd && CMD_CS == last_cs)
      need_val = cfg.rd_rd_same;  // [RULE3]
    else if (is_rd)
      need_val = cfg.rd_rd_diff;  // [RULE4]
    need_gap = is_col && (elapsed < need_val);
  end

  // a command is held, not refused: every spacing term must clear before it is taken
  assign space_ok = !need_gap
                    && !(is_act && last_bank_valid && CMD_BANK != last_bank && act_gap != 3'h0)  // [RULE5]
                    && (intr_ok || !(CMD_TYPE != dcst_pkg::CMD_NONE))  // [RULE9]
                    && (ck_state == DCST_CK_RUN);
  // accept is registered, so the requester still offers the same command one cycle after a take;
  // skipping that cycle keeps one command from being taken twice
  assign take = CMD_VALID && space_ok && CMD_READY && !CMD_ACCEPT;

  always_comb
  begin
    next_rd_gap          = {1'b0, rd_gap};
    next_last_cs         = last_cs;
    next_act_gap         = (act_gap != 3'h0) ? act_gap - 3'h1 : 3'h0;
    next_last_bank_valid = last_bank_valid;
    next_last_bank       = last_bank;
    if (rd_gap != 3'h0)
      next_rd_gap = {1'b0, rd_gap - 3'h1};
    if (take && is_rd)
    begin
      // status only: the widest turnaround that any follower could still need
      next_rd_gap  = {1'b0, max3(max3(cfg.rd_wr_same, cfg.rd_wr_diff), max3(cfg.rd_rd_same, cfg.rd_rd_diff))};
      next_last_cs = CMD_CS;
    end
    if (take && is_act)
    begin
      next_act_gap         = cfg.act_act;  // [RULE5]
      next_last_bank_valid = 1'b1;
      next_last_bank       = CMD_BANK;
    end
  end

  function automatic logic [2:0] max3(input logic [2:0] a, input logic [2:0] b);
    max3 = (a > b) ? a : b;
  endfunction

  // saturating counts of cycles since the last read and the last activate; 7 covers every 3-bit field
  always_comb
  begin
    next_elapsed   = (elapsed != 3'h7) ? elapsed + 3'h1 : elapsed;
    next_act_since = (act_since != 3'h7) ? act_since + 3'h1 : act_since;
    if (take && is_rd)
      next_elapsed = 3'h0;
    if (take && is_act)
      next_act_since = 3'h0;
  end

  // the clock-disable wait uses the programmed phy stop time
  always_comb
  begin
    next_ck_state = ck_state;
    next_ck_cnt   = ck_cnt;
    case (ck_state)
      DCST_CK_RUN:
        if (CLK_DISABLE_REQ && !burst_busy)
        begin
          next_ck_state = DCST_CK_WAIT;
          next_ck_cnt   = cfg.clk_disable;  // [RULE6]
        end
      // the count always runs out: a cancelled stop and a restart both give the pads their time
      DCST_CK_WAIT:
        if (ck_cnt != 3'h0)
          next_ck_cnt = ck_cnt - 3'h1;
        else if (CLK_DISABLE_REQ)
          next_ck_state = DCST_CK_OFF;
        else
          next_ck_state = DCST_CK_RUN;
      DCST_CK_OFF:
        if (!CLK_DISABLE_REQ)
        begin
          // re-enable also waits the same field: pads may need it to come back
          next_ck_state = DCST_CK_WAIT;
          next_ck_cnt   = cfg.clk_disable;  // [RULE7]
        end
      default:
        next_ck_state = DCST_CK_RUN;
    endcase
    next_cmd_ready = (next_ck_state == DCST_CK_RUN);
    next_pready    = PSEL && !PENABLE;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rd_gap               <= 3'h0;  // [RULE12]
      last_cs              <= 1'b0;
      act_gap              <= 3'h0;
      last_bank_valid      <= 1'b0;
      last_bank            <= 3'h0;
      elapsed              <= 3'h7;
      act_since            <= 3'h7;
      ck_state             <= DCST_CK_RUN;
      ck_cnt               <= 3'h0;
      CMD_READY            <= 1'b1;
      CMD_ACCEPT           <= 1'b0;
      PREADY               <= 1'b0;
      DFI_DRAM_CLK_DISABLE <= 1'b0;
      DRAM_CLK_STOPPED     <= 1'b0;
    end
    else
    begin
      rd_gap               <= next_rd_gap[2:0];
      last_cs              <= next_last_cs;
      act_gap              <= next_act_gap;
      last_bank_valid      <= next_last_bank_valid;
      last_bank            <= next_last_bank;
      elapsed              <= next_elapsed;
      act_since            <= next_act_since;
      ck_state             <= next_ck_state;
      ck_cnt               <= next_ck_cnt;
      CMD_READY            <= next_cmd_ready;
      CMD_ACCEPT           <= take;
      PREADY               <= next_pready;
      DFI_DRAM_CLK_DISABLE <= (next_ck_state != DCST_CK_RUN) && CLK_DISABLE_REQ;
      DRAM_CLK_STOPPED     <= (next_ck_state == DCST_CK_OFF);
    end
  end

  assign status = {24'h00_0000, 1'b0, ck_state, burst_busy, intr_ok, rd_gap != 3'h0, act_gap != 3'h0, last_cs};

  // a taken follower must have seen at least its own field of idle cycles since the last read
  a_rd_wr_same: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE1]
    (take && is_wr && CMD_CS == last_cs) |-> elapsed >= cfg.rd_wr_same)
    else $error("write too soon after read same cs");
  a_rd_wr_diff: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE2]
    (take && is_wr && CMD_CS != last_cs) |-> elapsed >= cfg.rd_wr_diff)
    else $error("write too soon after read other cs");
  a_rd_rd_same: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE3]
    (take && is_rd && CMD_CS == last_cs) |-> elapsed >= cfg.rd_rd_same)
    else $error("read too soon after read same cs");
  a_rd_rd_diff: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE4]
    (take && is_rd && CMD_CS != last_cs) |-> elapsed >= cfg.rd_rd_diff)
    else $error("read too soon after read other cs");
  // act_since is the gap to the previous activate less one
  a_act_space: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE5]
    (take && is_act && last_bank_valid && CMD_BANK != last_bank)
    |-> ({1'b0, act_since} + 4'h1 >= {1'b0, cfg.act_act}))
    else $error("activates too close");
  a_burst_guard: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE9]
    take |-> intr_ok) else $error("burst cut early");
  a_clk_stop: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE6]
    (ck_state == DCST_CK_RUN && CLK_DISABLE_REQ && !burst_busy)
    |=> (ck_state == DCST_CK_WAIT && ck_cnt == $past(cfg.clk_disable)))
    else $error("clock stop not timed by field");
  a_clk_off: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE6]
    (ck_state == DCST_CK_WAIT && ck_cnt == 3'h0 && CLK_DISABLE_REQ) |=> ck_state == DCST_CK_OFF)
    else $error("clock not stopped after field");
  a_clk_release: assert property (@(posedge CLK) disable iff (!RSTN)  // [RULE7]
    (ck_state == DCST_CK_OFF && !CLK_DISABLE_REQ)
    |=> (ck_state == DCST_CK_WAIT && ck_cnt == $past(cfg.clk_disable) && !CMD_READY))
    else $error("clock restart not timed by field");
  c_read: cover property (@(posedge CLK) take && is_rd);
  c_read_write: cover property (@(posedge CLK) take && is_rd ##[1:10] take && is_wr);
  c_act_act: cover property (@(posedge CLK) take && is_act ##[1:10] take && is_act);
  c_clk_off: cover property (@(posedge CLK) ck_state == DCST_CK_OFF);
  c_burst_cut: cover property (@(posedge CLK) take && burst_busy);
endmodule

// file: bench/dcst_phy_model.sv
// behavioural phy and dram side: clock-stop timing and command spacing log
`timescale 1ns/1ns
module dcst_phy_model
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  tdis,
  input  wire logic        clk_disable,
  input  wire logic        cmd_accept,
  output logic             clk_off,
  output logic      [15:0] last_gap
);
  logic [15:0] since;
  logic [3:0]  dis_cnt;
  // the memory clock is only gone tdis cycles after the disable strobe, never sooner
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dis_cnt <= 4'h0;
      clk_off <= 1'b0;
    end
    else if (clk_disable)
    begin
      dis_cnt <= (dis_cnt < 4'hf) ? dis_cnt + 4'h1 : dis_cnt;
      clk_off <= ({1'b0, tdis} <= dis_cnt);
    end
    else
    begin
      dis_cnt <= 4'h0;
      clk_off <= 1'b0;
    end
  end
  // cycles between successive commands seen on the dram side
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      since    <= 16'h0000;
      last_gap <= 16'h0000;
    end
    else if (cmd_accept)
    begin
      last_gap <= since;
      since    <= 16'h0001;
    end
    else
      since <= since + 16'h0001;
  end
endmodule

// file: bench/dram_command_spacing_timer_test.sv
// self-checking bench for the command spacing timer
`timescale 1ns/1ns
module dram_command_spacing_timer_test;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmd_valid = 1'b0;
  logic [2:0]  cmd_type = 3'h0;
  logic        cmd_cs = 1'b0;
  logic [2:0]  cmd_bank = 3'h0;
  logic        cmd_accept;
  logic        cmd_ready;
  logic        clk_dis_req = 1'b0;
  logic        dfi_dis;
  logic        stopped;
  logic [2:0]  tdis = 3'h3;
  logic        phy_off;
  logic [15:0] gap;
  int          fails = 0;
  int          check_count = 0;
  logic [2:0]  t2  [4] = '{dcst_pkg::CMD_WRITE, dcst_pkg::CMD_WRITE, dcst_pkg::CMD_READ, dcst_pkg::CMD_READ};
  logic        cs2 [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [15:0] mn  [4] = '{16'h0006, 16'h0005, 16'h0004, 16'h0003};
  logic [31:0] bt  [3] = '{32'h0603_0005, 32'h0603_0002, 32'h0603_0002};
  logic [31:0] ct  [3] = '{32'h0000_0701, 32'h0000_0704, 32'h0000_0701};
  int          idl [3] = '{0, 0, 3};
  logic [15:0] bmn [3] = '{16'h0005, 16'h0004, 16'h0004};

  dcst_top DUT
  (
    .CLK                  (clk),
    .RSTN                 (rstn),
    .PSEL                 (psel),
    .PENABLE              (penable),
    .PWRITE               (pwrite),
    .PADDR                (paddr),
    .PWDATA               (pwdata),
    .PRDATA               (prdata),
    .PREADY               (pready),
    .PSLVERR              (pslverr),
    .CMD_VALID            (cmd_valid),
    .CMD_TYPE             (cmd_type),
    .CMD_CS               (cmd_cs),
    .CMD_BANK             (cmd_bank),
    .CMD_ACCEPT           (cmd_accept),
    .CMD_READY            (cmd_ready),
    .CLK_DISABLE_REQ      (clk_dis_req),
    .DFI_DRAM_CLK_DISABLE (dfi_dis),
    .DRAM_CLK_STOPPED     (stopped)
  );

  dcst_phy_model phy
  (
    .clk         (clk),
    .rst_n       (rstn),
    .tdis        (tdis),
    .clk_disable (dfi_dis),
    .cmd_accept  (cmd_accept),
    .clk_off     (phy_off),
    .last_gap    (gap)
  );

  initial
  begin
    forever #2 clk = ~clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // spacing is only bounded from below: the design may wait longer than asked
  task automatic chk_ge(input logic [15:0] got, input logic [15:0] min);
    check_count++;
    if ((got >= min) !== 1'b1)
    begin
      fails++;
      $display("ERROR t=%0t gap=%h min=%h", $time, got, min);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic experr);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
    if (!wr)
      chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, experr});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cmd(input logic [2:0] t, input logic cs, input logic [2:0] b);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_type  <= t;
    cmd_cs    <= cs;
    cmd_bank  <= b;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cmd_accept !== 1'b1 && n < 200);
    cmd_valid <= 1'b0;
    if (cmd_accept !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
    @(posedge clk);
  endtask

  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (s !== v)
    begin
      fails++;
      wrap_up();
    end
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, dcst_pkg::ADDR_READ_TURNAROUND, 32'h0, dcst_pkg::RESET_READ_TURNAROUND, 1'b0);
    apb(1'b0, dcst_pkg::ADDR_ACT_CLK_BURST, 32'h0, dcst_pkg::RESET_ACT_CLK_BURST, 1'b0);
    apb(1'b0, dcst_pkg::ADDR_CMD_TIMING, 32'h0, dcst_pkg::RESET_CMD_TIMING, 1'b0);
    apb(1'b0, 8'h80, 32'h0, 32'h0000_0000, 1'b1);
    apb(1'b1, dcst_pkg::ADDR_STATUS, 32'hffff_ffff, 32'h0, 1'b1);
    apb(1'b1, dcst_pkg::ADDR_READ_TURNAROUND, 32'hffff_ffff, 32'h0, 1'b0);
    apb(1'b0, dcst_pkg::ADDR_READ_TURNAROUND, 32'h0, dcst_pkg::MASK_TURNAROUND, 1'b0);
    apb(1'b1, dcst_pkg::ADDR_READ_TURNAROUND, 32'h0504_0302, 32'h0, 1'b0);
    apb(1'b1, dcst_pkg::ADDR_ACT_CLK_BURST, 32'h0603_0001, 32'h0, 1'b0);
    apb(1'b1, dcst_pkg::ADDR_CMD_TIMING, 32'h0000_0101, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      cmd(dcst_pkg::CMD_READ, 1'b0, 3'h0);
      cmd(t2[i], cs2[i], 3'h0);
      @(posedge clk);
      chk_ge(gap, mn[i]);
    end
    cmd(dcst_pkg::CMD_ACT, 1'b0, 3'h1);
    cmd(dcst_pkg::CMD_ACT, 1'b0, 3'h2);
    @(posedge clk);
    chk_ge(gap, 16'h0006);
    apb(1'b1, dcst_pkg::ADDR_READ_TURNAROUND, 32'h0101_0101, 32'h0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, dcst_pkg::ADDR_ACT_CLK_BURST, bt[i], 32'h0, 1'b0);
      apb(1'b1, dcst_pkg::ADDR_CMD_TIMING, ct[i], 32'h0, 1'b0);
      cmd(dcst_pkg::CMD_READ, 1'b0, 3'h0);
      repeat (idl[i]) @(posedge clk);
      cmd(dcst_pkg::CMD_READ, 1'b1, 3'h0);
      @(posedge clk);
      chk_ge(gap, bmn[i]);
    end
    clk_dis_req <= 1'b1;
    wait_for(stopped, 1'b1);
    chk({29'h0, dfi_dis, cmd_ready, phy_off}, 32'h0000_0005);
    clk_dis_req <= 1'b0;
    wait_for(cmd_ready, 1'b1);
    chk({31'h0, stopped}, 32'h0);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, dcst_pkg::ADDR_READ_TURNAROUND, 32'h0, dcst_pkg::RESET_READ_TURNAROUND, 1'b0);
    wrap_up();
  end
endmodule
